// >>> core/pswc_pkg.sv
// Package of constants and carrier types for the PIO sector write command block.
`default_nettype none
package pswc_pkg;
  // ==========================================================================
  // Register map, byte addresses of 32-bit words
  localparam logic [7:0] OFF_SECTOR_COUNT = 8'h00;
  localparam logic [7:0] OFF_SECTOR_NUMBER = 8'h04;
  localparam logic [7:0] OFF_CYLINDER_LOW = 8'h08;
  localparam logic [7:0] OFF_CYLINDER_HIGH = 8'h0c;
  localparam logic [7:0] OFF_DEVICE_HEAD = 8'h10;
  localparam logic [7:0] OFF_COMMAND = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_DATA = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFF_CONFIG = 8'h28;
  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_SECT_A = 8'h30;
  localparam logic [7:0] OP_WRITE_SECT_B = 8'h31;
  localparam logic [7:0] OP_WRITE_SECT_EXT = 8'h34;
  localparam logic [7:0] OP_WRITE_MULT_COMMIT = 8'hce;
  // ==========================================================================
  // Field positions and reset values
  localparam int ST_ERROR_BIT = 0;
  localparam int ST_SENSE_BIT = 1;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_FAULT_BIT = 5;
  localparam int ST_BUSY_BIT = 7;
  localparam int IRQ_BLOCK_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_ERROR_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int CFG_CACHE_BIT = 8;
  localparam logic [7:0] TF_RESET = 8'h00;
  localparam logic [7:0] CFG_MULT_RESET = 8'h01;
  localparam logic CFG_CACHE_RESET = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  // ==========================================================================
  // Transfer geometry
  localparam int WORD_IDX_W = 8;
  localparam logic [WORD_IDX_W-1:0] LAST_WORD = 8'hff;
  localparam logic [16:0] COUNT28_ZERO = 17'h00100;
  localparam logic [16:0] COUNT48_ZERO = 17'h10000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Carriers to and from the media engine
  typedef struct packed {
    logic start;
    logic commit;
    logic [47:0] lba;
  } pswc_med_req_t;
  typedef struct packed {
    logic done;
    logic uncorrectable;
    logic fault;
  } pswc_med_rsp_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_MEDIA = 2'b11,
    ST_COMMIT = 2'b10
  } pswc_state_t;
endpackage : pswc_pkg
`default_nettype wire

// >>> core/pswc_sector_ram.sv
// One-sector buffer of 16-bit words with a registered read port.
`default_nettype none
module pswc_sector_ram
  import pswc_pkg::*;
(
  input wire logic core_clk,
  input wire logic wrEn,
  input wire logic [WORD_IDX_W-1:0] wrAddr,
  input wire logic [15:0] wrData,
  input wire logic [WORD_IDX_W-1:0] rdAddr,
  output logic [15:0] rdData
);
  logic [15:0] mem [0:(1<<WORD_IDX_W)-1];

  always_ff @(posedge core_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk)
  begin
    rdData <= mem[rdAddr];
  end
endmodule : pswc_sector_ram
`default_nettype wire

// >>> core/pswc_top.sv
// PIO sector write command interpreter with AXI4-Lite task file access.
`default_nettype none
module pswc_top
  import pswc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output pswc_med_req_t medReq,
  input wire pswc_med_rsp_t medRsp,
  input wire logic [WORD_IDX_W-1:0] medRdAddr,
  output logic [15:0] medRdData
);
  // ==========================================================================
  // Declarations
  pswc_state_t state_reg;
  logic awPend_reg, wPend_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg, rData_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bResp_reg, rResp_reg;
  logic [15:0] sectorCount_reg, sectorNumber_reg, cylinderLow_reg, cylinderHigh_reg;
  logic [7:0] deviceHead_reg, multSize_reg;
  logic cacheEn_reg;
  logic [IRQ_W-1:0] irqStat_reg, irqMask_reg, irqSet;
  logic [16:0] remain_reg;
  logic [47:0] lba_reg;
  logic [WORD_IDX_W-1:0] wordIdx_reg;
  logic [7:0] blkSize_reg, blkLeft_reg;
  logic commit_reg, ext_reg;
  logic errFlag_reg, senseFlag_reg, faultFlag_reg;
  pswc_med_req_t medReq_reg;
  logic doWrite, wrLow, isMapped, cmdWrite, is28, is48, isMult, cmdOk;
  logic dataWord, mediaBad, lastSector, finish, finishErr;
  logic [16:0] countNew;
  logic [15:0] countExt;
  logic [7:0] status;

  // ==========================================================================
  // AXI4-Lite slave
  function automatic logic regMapped(input logic [7:0] a);
    regMapped = (a[1:0] == 2'b00) && (a <= OFF_CONFIG);
  endfunction : regMapped

  assign s_axi_awready = !awPend_reg && !bvalid_reg;
  assign s_axi_wready = !wPend_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;
  assign doWrite = awPend_reg && wPend_reg && !bvalid_reg;
  assign isMapped = regMapped(awAddr_reg);
  assign wrLow = doWrite && wStrb_reg[0];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      awPend_reg <= 1'b0;
      wPend_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bResp_reg <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awPend_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wPend_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awPend_reg <= 1'b0;
        wPend_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bResp_reg <= isMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_comb
  begin
    status = 8'h00;
    status[ST_ERROR_BIT] = errFlag_reg;
    status[ST_SENSE_BIT] = senseFlag_reg;
    status[ST_FAULT_BIT] = faultFlag_reg;
    status[ST_DRQ_BIT] = (state_reg == ST_XFER);
    status[ST_BUSY_BIT] = (state_reg == ST_MEDIA) || (state_reg == ST_COMMIT);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid_reg <= 1'b0;
      rData_reg <= 32'h00000000;
      rResp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rResp_reg <= regMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_SECTOR_COUNT: rData_reg <= {16'h0000, sectorCount_reg};
        OFF_SECTOR_NUMBER: rData_reg <= {16'h0000, sectorNumber_reg};
        OFF_CYLINDER_LOW: rData_reg <= {16'h0000, cylinderLow_reg};
        OFF_CYLINDER_HIGH: rData_reg <= {16'h0000, cylinderHigh_reg};
        OFF_DEVICE_HEAD: rData_reg <= {24'h000000, deviceHead_reg};
        OFF_STATUS: rData_reg <= {24'h000000, status};
        OFF_IRQ_STATUS: rData_reg <= {29'h00000000, irqStat_reg};
        OFF_IRQ_MASK: rData_reg <= {29'h00000000, irqMask_reg};
        OFF_CONFIG: rData_reg <= {23'h000000, cacheEn_reg, multSize_reg};
        default: rData_reg <= 32'h00000000;
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Command decode
  assign cmdWrite = wrLow && (awAddr_reg == OFF_COMMAND) && (state_reg == ST_IDLE);
  // Bit 0 of 30h/31h is the retry flag, so masking it decodes both alike.
  assign is28 = (wData_reg[7:1] == OP_WRITE_SECT_A[7:1]);
  assign is48 = (wData_reg[7:0] == OP_WRITE_SECT_EXT);
  assign isMult = (wData_reg[7:0] == OP_WRITE_MULT_COMMIT);
  assign cmdOk = is28 || is48 || isMult;
  assign countExt = sectorCount_reg;
  always_comb
  begin
    if (is28)
    begin
      countNew = (sectorCount_reg[7:0] == 8'h00) ? COUNT28_ZERO : {9'h000, sectorCount_reg[7:0]};
    end
    else
    begin
      countNew = (countExt == 16'h0000) ? COUNT48_ZERO : {1'b0, countExt};
    end
  end

  // ==========================================================================
  // Sector sequencing
  assign dataWord = wrLow && wStrb_reg[1] && (awAddr_reg == OFF_DATA) && (state_reg == ST_XFER);
  assign mediaBad = medRsp.uncorrectable || medRsp.fault;
  assign lastSector = (remain_reg == 17'h00001);
  assign finishErr = (cmdWrite && !cmdOk) ||
    (((state_reg == ST_MEDIA) || (state_reg == ST_COMMIT)) && medRsp.done && mediaBad);
  assign finish = finishErr ||
    ((state_reg == ST_MEDIA) && medRsp.done && !mediaBad && lastSector && !commit_reg) ||
    ((state_reg == ST_COMMIT) && medRsp.done && !mediaBad);

  pswc_sector_ram u_ram (
    .core_clk(core_clk),
    .wrEn(dataWord),
    .wrAddr(wordIdx_reg),
    .wrData(wData_reg[15:0]),
    .rdAddr(medRdAddr),
    .rdData(medRdData)
  );

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      remain_reg <= 17'h00000;
      lba_reg <= 48'h000000000000;
      wordIdx_reg <= '0;
      blkSize_reg <= 8'h01;
      blkLeft_reg <= 8'h01;
      commit_reg <= 1'b0;
      ext_reg <= 1'b0;
      medReq_reg <= '0;
    end
    else
    begin
      medReq_reg.start <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (cmdWrite && cmdOk)
          begin
            state_reg <= ST_XFER;
            remain_reg <= countNew;
            ext_reg <= !is28;
            wordIdx_reg <= '0;
            if (is28)
            begin
              lba_reg <= {20'h00000, deviceHead_reg[3:0], cylinderHigh_reg[7:0],
                cylinderLow_reg[7:0], sectorNumber_reg[7:0]};
            end
            else
            begin
              lba_reg <= {cylinderHigh_reg[15:8], cylinderLow_reg[15:8], sectorNumber_reg[15:8],
                cylinderHigh_reg[7:0], cylinderLow_reg[7:0], sectorNumber_reg[7:0]};
            end
            blkSize_reg <= (isMult && (multSize_reg != 8'h00)) ? multSize_reg : 8'h01;
            blkLeft_reg <= (isMult && (multSize_reg != 8'h00)) ? multSize_reg : 8'h01;
            commit_reg <= isMult || !cacheEn_reg;
          end
        end
        ST_XFER:
        begin
          if (dataWord)
          begin
            wordIdx_reg <= wordIdx_reg + 8'h01;
            if (wordIdx_reg == LAST_WORD)
            begin
              state_reg <= ST_MEDIA;
              medReq_reg.start <= 1'b1;
              medReq_reg.commit <= 1'b0;
              medReq_reg.lba <= lba_reg;
            end
          end
        end
        ST_MEDIA:
        begin
          if (medRsp.done)
          begin
            if (mediaBad)
            begin
              state_reg <= ST_IDLE;
            end
            else if (lastSector)
            begin
              remain_reg <= 17'h00000;
              if (commit_reg)
              begin
                state_reg <= ST_COMMIT;
                medReq_reg.start <= 1'b1;
                medReq_reg.commit <= 1'b1;
              end
              else
              begin
                state_reg <= ST_IDLE;
              end
            end
            else
            begin
              state_reg <= ST_XFER;
              remain_reg <= remain_reg - 17'h00001;
              lba_reg <= lba_reg + 48'h000000000001;
              blkLeft_reg <= (blkLeft_reg == 8'h01) ? blkSize_reg : blkLeft_reg - 8'h01;
            end
          end
        end
        ST_COMMIT:
        begin
          if (medRsp.done)
          begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign medReq = medReq_reg;

  // ==========================================================================
  // Ending status flags
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      errFlag_reg <= 1'b0;
      senseFlag_reg <= 1'b0;
      faultFlag_reg <= 1'b0;
    end
    else if (cmdWrite)
    begin
      errFlag_reg <= !cmdOk;
      senseFlag_reg <= 1'b0;
      faultFlag_reg <= 1'b0;
    end
    else if (finishErr)
    begin
      errFlag_reg <= 1'b1;
      senseFlag_reg <= medRsp.uncorrectable;
      faultFlag_reg <= medRsp.fault;
    end
  end

  // ==========================================================================
  // Task file: host writes push current into previous (device/head is overwritten), completion writes back
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sectorCount_reg <= {TF_RESET, TF_RESET};
      sectorNumber_reg <= {TF_RESET, TF_RESET};
      cylinderLow_reg <= {TF_RESET, TF_RESET};
      cylinderHigh_reg <= {TF_RESET, TF_RESET};
      deviceHead_reg <= TF_RESET;
    end
    else if (finish && (state_reg != ST_IDLE))
    begin
      if (ext_reg)
      begin
        sectorCount_reg <= finishErr ? remain_reg[15:0] : 16'h0000;
        sectorNumber_reg <= {lba_reg[31:24], lba_reg[7:0]};
        cylinderLow_reg <= {lba_reg[39:32], lba_reg[15:8]};
        cylinderHigh_reg <= {lba_reg[47:40], lba_reg[23:16]};
      end
      else
      begin
        sectorCount_reg[7:0] <= finishErr ? remain_reg[7:0] : 8'h00;
        sectorNumber_reg[7:0] <= lba_reg[7:0];
        cylinderLow_reg[7:0] <= lba_reg[15:8];
        cylinderHigh_reg[7:0] <= lba_reg[23:16];
        deviceHead_reg[3:0] <= lba_reg[27:24];
      end
    end
    else if (wrLow && (state_reg == ST_IDLE))
    begin
      case (awAddr_reg)
        OFF_SECTOR_COUNT: sectorCount_reg <= {sectorCount_reg[7:0], wData_reg[7:0]};
        OFF_SECTOR_NUMBER: sectorNumber_reg <= {sectorNumber_reg[7:0], wData_reg[7:0]};
        OFF_CYLINDER_LOW: cylinderLow_reg <= {cylinderLow_reg[7:0], wData_reg[7:0]};
        OFF_CYLINDER_HIGH: cylinderHigh_reg <= {cylinderHigh_reg[7:0], wData_reg[7:0]};
        OFF_DEVICE_HEAD: deviceHead_reg <= wData_reg[7:0];
        default: deviceHead_reg <= deviceHead_reg;
      endcase
    end
  end

  // ==========================================================================
  // Configuration and interrupts
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      multSize_reg <= CFG_MULT_RESET;
      cacheEn_reg <= CFG_CACHE_RESET;
      irqMask_reg <= IRQ_MASK_RESET;
    end
    else if (doWrite)
    begin
      if ((awAddr_reg == OFF_CONFIG) && (state_reg == ST_IDLE))
      begin
        if (wStrb_reg[0])
        begin
          multSize_reg <= wData_reg[7:0];
        end
        if (wStrb_reg[1])
        begin
          cacheEn_reg <= wData_reg[CFG_CACHE_BIT];
        end
      end
      if (wrLow && (awAddr_reg == OFF_IRQ_MASK))
      begin
        irqMask_reg <= wData_reg[IRQ_W-1:0];
      end
    end
  end

  always_comb
  begin
    irqSet = '0;
    irqSet[IRQ_BLOCK_BIT] = (state_reg == ST_MEDIA) && medRsp.done && !mediaBad &&
      !lastSector && (blkLeft_reg == 8'h01);
    irqSet[IRQ_DONE_BIT] = finish;
    irqSet[IRQ_ERROR_BIT] = finishErr;
  end

  // A set in the clearing cycle survives, so no event is lost.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irqStat_reg <= '0;
    end
    else if (wrLow && (awAddr_reg == OFF_IRQ_STATUS))
    begin
      irqStat_reg <= (irqStat_reg & ~wData_reg[IRQ_W-1:0]) | irqSet;
    end
    else
    begin
      irqStat_reg <= irqStat_reg | irqSet;
    end
  end
  assign irq = |(irqStat_reg & irqMask_reg);
endmodule : pswc_top
`default_nettype wire

// >>> test/pswc_checker.sv
// Concurrent checks on the ports of the PIO sector write command block.
`default_nettype none
module pswc_checker
  import pswc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire pswc_med_req_t medReq,
  input wire pswc_med_rsp_t medRsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cmdFresh_reg;
  logic [47:0] lastLba_reg;
  int words_reg;
  wire logic wrHs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic arHs = s_axi_arvalid && s_axi_arready;
  wire logic badAw = (s_axi_awaddr > 8'h28) || (s_axi_awaddr[1:0] != 2'h0);
  wire logic badAr = (s_axi_araddr > 8'h28) || (s_axi_araddr[1:0] != 2'h0);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Helper state
  // The first sector of a command has no predecessor, so the address chain restarts there.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmdFresh_reg <= 1'b1;
      lastLba_reg <= '0;
      words_reg <= 0;
    end
    else
    begin
      if (wrHs && s_axi_awaddr == OFF_COMMAND)
        cmdFresh_reg <= 1'b1;
      else if (medReq.start)
        cmdFresh_reg <= 1'b0;
      if (medReq.start && !medReq.commit)
        lastLba_reg <= medReq.lba;
      if (medReq.start)
        words_reg <= 0;
      else if (wrHs && s_axi_awaddr == OFF_DATA)
        words_reg <= words_reg + 1;
    end
  end
  // ==========================================
  // Assertions
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready does not follow rvalid");
  rd_next_a: assert property (arHs && !badAr |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
    else $error("mapped read not answered okay");
  rd_err_a: assert property (arHs && badAr |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  wr_resp_a: assert property (wrHs && !badAw |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_OKAY))
    else $error("write response missing");
  wr_err_a: assert property (wrHs && badAw |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
    else $error("unmapped write not refused");
  start_pulse_a: assert property (medReq.start |=> !medReq.start)
    else $error("media start longer than one cycle");
  sector_words_a: assert property (medReq.start && !medReq.commit |-> words_reg == 256)
    else $error("sector started without 256 words");
  lba_next_a: assert property (medReq.start && !medReq.commit && !cmdFresh_reg |-> medReq.lba == lastLba_reg + 48'h1)
    else $error("sector address not consecutive");
  stop_err_a: assert property (medRsp.done && medRsp.uncorrectable |=> !medReq.start [*8])
    else $error("write continued after failing sector");
endmodule : pswc_checker
bind pswc_top pswc_checker pswc_checker_inst (.*);
`default_nettype wire

// >>> test/pswc_media_model.sv
// Behavioural media engine that drains the sector buffer and answers requests.
`default_nettype none
module pswc_media_model
  import pswc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire pswc_med_req_t medReq,
  output pswc_med_rsp_t medRsp,
  output logic [WORD_IDX_W-1:0] medRdAddr,
  input wire logic [15:0] medRdData,
  input wire logic [47:0] failLba,
  output logic [31:0] mSum
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic busy;
  logic bad;
  // ==========================================
  // Media engine
  // Good answers come late on purpose, so ending status cannot race ahead of the media.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      bad <= 1'b0;
      cnt <= 0;
      medRsp <= '0;
      medRdAddr <= '0;
      mSum <= '0;
    end
    else
    begin
      medRsp <= '0;
      medRdAddr <= cnt[7:0];
      if (medReq.start)
      begin
        busy <= 1'b1;
        cnt <= 0;
        mSum <= '0;
        bad <= !medReq.commit && (medReq.lba == failLba);
      end
      else if (busy)
      begin
        cnt <= cnt + 1;
        if (cnt >= 2 && cnt < 258)
          mSum <= mSum + {16'h0, medRdData};
        if (cnt == (bad ? 258 : 275))
        begin
          busy <= 1'b0;
          medRsp <= '{done: 1'b1, uncorrectable: bad, fault: 1'b0};
        end
      end
    end
  end
endmodule : pswc_media_model
`default_nettype wire

// >>> test/pswc_top_tb.sv
// Self-checking testbench of the PIO sector write command block.
`default_nettype none
module pswc_top_tb
  import pswc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, irq, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, mSum, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, bResp, rResp;
  logic [WORD_IDX_W-1:0] medRdAddr;
  logic [15:0] medRdData;
  logic [47:0] failLba;
  logic lastCmt, cacheOn = 1'b1;
  pswc_med_req_t medReq;
  pswc_med_rsp_t medRsp;
  int n_mismatch, n_compared, seed, cyc;
  logic [63:0] gotQ[$], expQ[$], sumQ[$], eSumQ[$];
  pswc_top pswc_top_inst (.*);
  pswc_media_model pswc_media_model_inst (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ==========================================
  // Monitor and watchdog
  always @(posedge core_clk)
  begin
    cyc++;
    if (medReq.start)
      gotQ.push_back({medReq.commit, medReq.commit ? 48'h0 : medReq.lba});
    if (medReq.start)
      lastCmt <= medReq.commit;
    if (medRsp.done && !lastCmt)
      sumQ.push_back(mSum);
    if (cyc == 60000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ==========================================
  // Tasks
  task automatic cmp_val(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_val
  task automatic cmp_q(ref logic [63:0] g[$], ref logic [63:0] e[$]);
    cmp_val(g.size(), e.size());
    while (g.size() > 0 && e.size() > 0)
      cmp_val(g.pop_front(), e.pop_front());
    g.delete();
    e.delete();
  endtask : cmp_q
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    bResp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rResp = s_axi_rresp;
  endtask : rd
  task automatic cmd(input logic [7:0] op, input logic [15:0] cnt, input logic [47:0] lba, input logic [47:0] fl);
    logic ext, cmt, bad;
    logic [15:0] m;
    logic [31:0] s;
    logic [47:0] cur;
    int n, drv, i, w;
    ext = (op == OP_WRITE_SECT_EXT) || (op == OP_WRITE_MULT_COMMIT);
    cmt = (op == OP_WRITE_MULT_COMMIT);
    m = ext ? 16'hffff : 16'h00ff;
    n = ext ? ((cnt == 16'h0) ? 65536 : int'(cnt)) : ((cnt[7:0] == 8'h0) ? 256 : int'(cnt[7:0]));
    failLba <= fl;
    for (i = 0; i < 2; i++)
    begin
      wr(OFF_SECTOR_COUNT, cnt[15-8*i -: 8]);
      wr(OFF_SECTOR_NUMBER, lba[31-24*i -: 8]);
      wr(OFF_CYLINDER_LOW, lba[39-24*i -: 8]);
      wr(OFF_CYLINDER_HIGH, lba[47-24*i -: 8]);
    end
    wr(OFF_DEVICE_HEAD, {4'h4, lba[27:24]});
    wr(OFF_COMMAND, op);
    drv = 0;
    bad = 1'b0;
    while (!bad && drv < n)
    begin
      do rd(OFF_STATUS, v); while (v[ST_BUSY_BIT] && !v[ST_DRQ_BIT]);
      if (drv > 0)
      begin
        rd(OFF_IRQ_STATUS, v);
        cmp_val(v[IRQ_BLOCK_BIT], cmt ? (drv % 2 == 0) : 1'b1);
        wr(OFF_IRQ_STATUS, 32'h1);
      end
      s = 0;
      for (w = 0; w < 256; w++)
      begin
        v = $random(seed);
        s += v[15:0];
        wr(OFF_DATA, v);
      end
      cur = lba + drv;
      expQ.push_back({1'b0, cur});
      eSumQ.push_back(s);
      bad = (cur == fl);
      drv++;
    end
    if (!bad && (cmt || !cacheOn))
      expQ.push_back({1'b1, 48'h0});
    do rd(OFF_STATUS, v); while (v[ST_BUSY_BIT]);
    cmp_val(v[7:0], bad ? 8'h03 : 8'h00);
    cur = bad ? fl : lba + drv - 1;
    s = bad ? n - drv + 1 : 0;
    rd(OFF_SECTOR_COUNT, v);
    cmp_val(v[15:0] & m, s[15:0] & m);
    rd(OFF_SECTOR_NUMBER, v);
    cmp_val(v[15:0] & m, {cur[31:24], cur[7:0]} & m);
    rd(OFF_CYLINDER_LOW, v);
    cmp_val(v[15:0] & m, {cur[39:32], cur[15:8]} & m);
    rd(OFF_CYLINDER_HIGH, v);
    cmp_val(v[15:0] & m, {cur[47:40], cur[23:16]} & m);
    rd(OFF_DEVICE_HEAD, v);
    cmp_val(v[7:0], {4'h4, ext ? lba[27:24] : cur[27:24]});
    rd(OFF_IRQ_STATUS, v);
    cmp_val(v[2:1], {bad, 1'b1});
    cmp_val(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h2);
    @(posedge core_clk);
    cmp_val(irq, 1'b1);
    wr(OFF_IRQ_STATUS, 32'h7);
    @(posedge core_clk);
    cmp_val(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h0);
    cmp_q(gotQ, expQ);
    cmp_q(sumQ, eSumQ);
  endtask : cmd
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Main sequence
  initial
  begin
    seed = 32'h5d72;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    failLba = '1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(OFF_CONFIG, v);
    cmp_val(v, {CFG_CACHE_RESET, CFG_MULT_RESET});
    rd(OFF_IRQ_MASK, v);
    cmp_val(v, IRQ_MASK_RESET);
    rd(OFF_SECTOR_COUNT, v);
    cmp_val(v, TF_RESET);
    rd(8'h2c, v);
    cmp_val({rResp, v}, {RESP_SLVERR, 32'h0});
    wr(8'h2a, 32'h0);
    cmp_val(bResp, RESP_SLVERR);
    wr(OFF_COMMAND, 32'h20);
    rd(OFF_STATUS, v);
    cmp_val(v[7:0], 8'h01);
    rd(OFF_IRQ_STATUS, v);
    cmp_val(v[2:0], 3'h6);
    wr(OFF_IRQ_STATUS, 32'h7);
    wr(OFF_CONFIG, 32'h102);
    cmd(OP_WRITE_SECT_A, 16'h0, 48'h0abcdef, 48'h0abcdf0);
    cmd(OP_WRITE_SECT_B, 16'h2, 48'h5123456, '1);
    cmd(OP_WRITE_SECT_EXT, 16'h0, 48'h123456789abc, 48'h123456789abd);
    cmd(OP_WRITE_MULT_COMMIT, 16'h3, 48'h0000fffffffe, '1);
    wr(OFF_CONFIG, 32'h2);
    cacheOn = 1'b0;
    cmd(OP_WRITE_SECT_EXT, 16'h1, 48'h00a5a5a5a5a5, '1);
    report_and_stop();
  end
endmodule : pswc_top_tb
`default_nettype wire
